//--- shared/uart_regmap_pkg.sv
/*
 Constants for the UART channel register map and receive interrupts.
 Assumes a host on an 8-bit parallel bus with a 3-bit address.
*/
// Function
// - Extended bits exist only while enhanced enable bit 4 is set.
// - Enable opens mask[7:4], fifo[5:4], modem[7:5], fraction.
// - Fraction at 010 needs line[7]=1, line not 0xBF, enable set; 4 bits.
// - Feature: mode, scratch swap, trigger table, duplex, IR, hysteresis.
// - Mask gates rx ready, tx empty, line status, modem status sources.
// - FIFO rx interrupt mode: fifo bit 0, mask bit 0; source bits 7,6 set, code 4.
// - In FIFO mode rx interrupt rises when fill level reaches trigger.
// - Rx interrupt drops once reads bring fill level below trigger.
// - Source shows rx level status; clears with interrupt below trigger.
// - Data ready sets when a character enters FIFO, clears when empty.
// - Enhanced bank only at line control 0xBF; flow chars at 100-111.
package uart_regmap_pkg;
   // ----------------------------------------------------------------
   // Offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_MASK = 3'h1;
   localparam logic [2:0] OFS_SRC = 3'h2;
   localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
   localparam logic [2:0] OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
   localparam logic [2:0] OFS_SCRATCH = 3'h7;
   localparam logic [2:0] OFS_DIV_LOW = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
   localparam logic [2:0] OFS_FRACTION = 3'h2;
   localparam logic [2:0] OFS_TRIGGER = 3'h0;
   localparam logic [2:0] OFS_FEATURE = 3'h1;
   localparam logic [2:0] OFS_ENHANCED = 3'h2;
   localparam logic [2:0] OFS_RESUME1 = 3'h4;
   // ----------------------------------------------------------------
   // Fields and keys
   // ----------------------------------------------------------------
   localparam logic [7:0] ENH_BANK_KEY = 8'hbf;
   localparam int ENH_ENABLE_BIT = 4;
   localparam int LINE_DIV_BIT = 7;
   localparam int FEAT_SWAP_BIT = 6;
   localparam int FEAT_IR_BIT = 2;
   localparam int FIFO_ENABLE_BIT = 0;
   localparam int FIFO_RXRST_BIT = 1;
   localparam logic [1:0] TRIG_TABLE_PROG = 2'h3;
   localparam logic [3:0][7:0] TRIG_TABLE = {8'h0e, 8'h08, 8'h04, 8'h01};
   // ----------------------------------------------------------------
   // Reset values and source codes
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [3:0] SRC_LINE = 4'h6;
   localparam logic [3:0] SRC_RX = 4'h4;
   localparam logic [3:0] SRC_TX = 4'h2;
   localparam logic [3:0] SRC_MODEM = 4'h0;
   localparam logic [3:0] SRC_NONE = 4'h1;
   localparam int FIFO_DEPTH_DEF = 64;
endpackage : uart_regmap_pkg

//--- shared/rx_path_if.sv
/*
 Receive path signals between the register map, store and evaluator.
 Assumes one clock domain shared by all users.
*/
`timescale 1ns/1ps
interface rx_path_if #(parameter int DW = 8, parameter int LW = 8);
   logic push;
   logic [DW-1:0] push_data;
   logic pop;
   logic flush;
   logic [DW-1:0] head_data;
   logic [LW-1:0] level;
   logic empty;
   logic [LW-1:0] trigger;
   logic fifo_en;
   logic [3:0] mask;
   logic tx_empty;
   logic line_err;
   logic modem_chg;
   logic [3:0] src_code;
   logic pending;
   modport store(input push, push_data, pop, flush,
      output head_data, level, empty);
   modport eval(input level, empty, trigger, fifo_en, mask, tx_empty,
      line_err, modem_chg, output src_code, pending);
endinterface : rx_path_if

//--- src/rx_char_store.sv
/*
 Receive character store with fill level counter.
 Assumes DEPTH a power of two, below 256; push when full is dropped.
*/
`timescale 1ns/1ps
module rx_char_store
   import uart_regmap_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   rx_path_if.store bus
);
   localparam int AW = $clog2(DEPTH);
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [7:0] cnt_q, cnt_d;
   logic wen, ren;

   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      wen = bus.push && (cnt_q != 8'(DEPTH));
      ren = bus.pop && (cnt_q != 8'h00);
      if (bus.flush) begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = 8'h00;
         wen = 1'b0;
      end else begin
         if (wen) wp_d = wp_q + 1'b1;
         if (ren) rp_d = rp_q + 1'b1;
         case ({wen, ren})
            2'b10: cnt_d = cnt_q + 1'b1;
            2'b01: cnt_d = cnt_q - 1'b1;
            default: cnt_d = cnt_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= 8'h00;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // No reset on storage, contents are don't-care while empty
   always_ff @(posedge clk_i) begin
      if (wen) mem[wp_q] <= bus.push_data;
   end

   assign bus.head_data = mem[rp_q];
   assign bus.level = cnt_q;
   assign bus.empty = (cnt_q == 8'h00);
endmodule : rx_char_store

//--- src/rx_irq_eval.sv
/*
 Interrupt source selection for one channel, purely combinational.
 Assumes line and modem events are held high by their owners.
*/
`timescale 1ns/1ps
module rx_irq_eval
   import uart_regmap_pkg::*;
(
   rx_path_if.eval bus
);
   logic rx_hit;

   always_comb begin
      // Non-FIFO mode: any held character counts
      rx_hit = !bus.empty;
      if (bus.fifo_en) begin
         rx_hit = !bus.empty && (bus.level >= bus.trigger);
      end
      // Fixed priority, line status first
      if (bus.mask[2] && bus.line_err) begin
         bus.src_code = SRC_LINE;
      end else if (bus.mask[0] && rx_hit) begin
         bus.src_code = SRC_RX;
      end else if (bus.mask[1] && bus.tx_empty) begin
         bus.src_code = SRC_TX;
      end else if (bus.mask[3] && bus.modem_chg) begin
         bus.src_code = SRC_MODEM;
      end else begin
         bus.src_code = SRC_NONE;
      end
      bus.pending = (bus.src_code != SRC_NONE);
   end
endmodule : rx_irq_eval

//--- src/uart_regmap_top.sv
/*
 Register map and receive interrupt logic of one UART channel.
 Assumes a synchronous host bus: one-cycle rd_i/wr_i strobes, address
 and data valid with them; read data appears one cycle later.
*/
`timescale 1ns/1ps
module uart_regmap_top
   import uart_regmap_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF,
   parameter bit CHANNEL_B = 1'b0,
   // Arbitrary identification values
   parameter logic [7:0] DEVICE_ID = 8'h5c,
   parameter logic [7:0] REVISION = 8'h01
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic rx_push_i,
   input wire logic [7:0] rx_char_i,
   input wire logic tx_empty_i,
   input wire logic line_err_i,
   input wire logic modem_chg_i,
   input wire logic [7:0] modem_stat_i,
   output logic irq_o,
   output logic [15:0] divisor_o,
   output logic [3:0] fraction_o,
   output logic [7:0] feature_o,
   output logic [7:0] enhanced_o,
   output logic [7:0] line_ctrl_o,
   output logic [7:0] modem_ctrl_o
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] lctl_q, lctl_d;
   logic [7:0] dvlo_q, dvlo_d;
   logic [7:0] dvhi_q, dvhi_d;
   logic [3:0] frac_q, frac_d;
   logic [7:0] feat_q, feat_d;
   logic [7:0] enh_q, enh_d;
   logic [7:0] trig_q, trig_d;
   logic [7:0] imask_q, imask_d;
   logic [7:0] fifoc_q, fifoc_d;
   logic [7:0] mcr_q, mcr_d;
   logic [7:0] spr_q, spr_d;
   logic [7:0] emsr_q, emsr_d;
   logic [3:0][7:0] chars_q, chars_d;
   logic [7:0] rdata_q, rdata_d;
   logic irq_q, irq_d;

   logic enh_bank, div_bank, ext_on, divs_zero;
   logic div_lo, frac_sel, norm_sel;
   logic [7:0] mask_vis, mcr_vis;

   rx_path_if #(.DW(8), .LW(8)) ev ();

   // ----------------------------------------------------------------
   // Bank decode
   // ----------------------------------------------------------------
   assign enh_bank = (lctl_q == ENH_BANK_KEY);
   assign div_bank = lctl_q[LINE_DIV_BIT] && !enh_bank;
   assign ext_on = enh_q[ENH_ENABLE_BIT];
   assign divs_zero = (dvlo_q == 8'h00) && (dvhi_q == 8'h00);
   assign div_lo = div_bank && (addr_i[2:1] == 2'b00);
   // Fraction hidden when disabled; the normal register shows through
   assign frac_sel = div_bank && ext_on && (addr_i == OFS_FRACTION);
   assign norm_sel = !enh_bank && !div_lo && !frac_sel;
   assign mask_vis = ext_on ? imask_q : {4'h0, imask_q[3:0]};
   assign mcr_vis = ext_on ? mcr_q : {3'h0, mcr_q[4:0]};

   // ----------------------------------------------------------------
   // Receive path hookup
   // ----------------------------------------------------------------
   assign ev.push = rx_push_i;
   assign ev.push_data = rx_char_i;
   // Reading the holding register consumes one character
   assign ev.pop = rd_i && norm_sel && (addr_i == OFS_DATA);
   assign ev.flush = wr_i && norm_sel && (addr_i == OFS_SRC)
      && wdata_i[FIFO_ENABLE_BIT] && wdata_i[FIFO_RXRST_BIT];
   assign ev.fifo_en = fifoc_q[FIFO_ENABLE_BIT];
   assign ev.trigger = (feat_q[5:4] == TRIG_TABLE_PROG) ? trig_q
      : TRIG_TABLE[fifoc_q[7:6]];
   assign ev.mask = imask_q[3:0];
   assign ev.tx_empty = tx_empty_i;
   assign ev.line_err = line_err_i;
   assign ev.modem_chg = modem_chg_i;

   rx_char_store #(.DEPTH(DEPTH)) u_store (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .bus(ev)
   );

   rx_irq_eval u_eval (
      .bus(ev)
   );

   // ----------------------------------------------------------------
   // Register writes and read mux
   // ----------------------------------------------------------------
   always_comb begin
      lctl_d = lctl_q;
      dvlo_d = dvlo_q;
      dvhi_d = dvhi_q;
      frac_d = frac_q;
      feat_d = feat_q;
      enh_d = enh_q;
      trig_d = trig_q;
      imask_d = imask_q;
      fifoc_d = fifoc_q;
      mcr_d = mcr_q;
      spr_d = spr_q;
      emsr_d = emsr_q;
      chars_d = chars_q;
      rdata_d = rdata_q;
      irq_d = ev.pending;
      if (wr_i) begin
         if (addr_i == OFS_LINE_CTRL) begin
            lctl_d = wdata_i;
         end else if (enh_bank) begin
            case (addr_i)
               OFS_TRIGGER: trig_d = wdata_i;
               OFS_FEATURE: begin
                  feat_d = wdata_i;
                  if (!CHANNEL_B) feat_d[FEAT_IR_BIT] = 1'b0;
               end
               OFS_ENHANCED: enh_d = wdata_i;
               default: begin
                  if (addr_i[2]) chars_d[addr_i[1:0]] = wdata_i;
               end
            endcase
         end else if (div_lo) begin
            if (addr_i[0]) dvhi_d = wdata_i;
            else dvlo_d = wdata_i;
         end else if (frac_sel) begin
            frac_d = wdata_i[3:0];
         end else begin
            case (addr_i)
               OFS_MASK: begin
                  imask_d[3:0] = wdata_i[3:0];
                  if (ext_on) imask_d[7:4] = wdata_i[7:4];
               end
               OFS_SRC: begin
                  // Other bits only take effect with the enable bit set
                  fifoc_d[FIFO_ENABLE_BIT] = wdata_i[FIFO_ENABLE_BIT];
                  if (wdata_i[FIFO_ENABLE_BIT]) begin
                     fifoc_d[7:6] = wdata_i[7:6];
                     fifoc_d[3] = wdata_i[3];
                     fifoc_d[2:1] = 2'b00;
                     if (ext_on) fifoc_d[5:4] = wdata_i[5:4];
                  end
               end
               OFS_MODEM_CTRL: begin
                  mcr_d[4:0] = wdata_i[4:0];
                  if (ext_on) mcr_d[7:5] = wdata_i[7:5];
               end
               OFS_SCRATCH: begin
                  if (feat_q[FEAT_SWAP_BIT]) emsr_d = wdata_i;
                  else spr_d = wdata_i;
               end
               default: begin
               end
            endcase
         end
      end
      if (rd_i) begin
         if (addr_i == OFS_LINE_CTRL) begin
            rdata_d = lctl_q;
         end else if (enh_bank) begin
            case (addr_i)
               OFS_TRIGGER: rdata_d = ev.level;
               OFS_FEATURE: rdata_d = feat_q;
               OFS_ENHANCED: rdata_d = enh_q;
               default: rdata_d = chars_q[addr_i[1:0]];
            endcase
         end else if (div_lo) begin
            // Identity shows only while both divisor bytes are zero
            if (addr_i[0]) begin
               rdata_d = divs_zero ? DEVICE_ID : dvhi_q;
            end else begin
               rdata_d = divs_zero ? REVISION : dvlo_q;
            end
         end else if (frac_sel) begin
            rdata_d = {4'h0, frac_q};
         end else begin
            case (addr_i)
               OFS_DATA: rdata_d = ev.head_data;
               OFS_MASK: rdata_d = mask_vis;
               OFS_SRC: rdata_d = {{2{fifoc_q[FIFO_ENABLE_BIT]}}, 2'b00,
                  ev.src_code};
               OFS_MODEM_CTRL: rdata_d = mcr_vis;
               OFS_LINE_STAT: rdata_d = {line_err_i, tx_empty_i,
                  tx_empty_i, 4'h0, !ev.empty};
               OFS_MODEM_STAT: rdata_d = modem_stat_i;
               OFS_SCRATCH: begin
                  // Swapped slot reports the receive fill level
                  rdata_d = feat_q[FEAT_SWAP_BIT] ? ev.level : spr_q;
               end
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lctl_q <= RST_REG;
         dvlo_q <= RST_REG;
         dvhi_q <= RST_REG;
         frac_q <= 4'h0;
         feat_q <= RST_REG;
         enh_q <= RST_REG;
         trig_q <= RST_REG;
         imask_q <= RST_REG;
         fifoc_q <= RST_REG;
         mcr_q <= RST_REG;
         spr_q <= RST_REG;
         emsr_q <= RST_REG;
         chars_q <= '0;
         rdata_q <= RST_REG;
         irq_q <= 1'b0;
      end else begin
         lctl_q <= lctl_d;
         dvlo_q <= dvlo_d;
         dvhi_q <= dvhi_d;
         frac_q <= frac_d;
         feat_q <= feat_d;
         enh_q <= enh_d;
         trig_q <= trig_d;
         imask_q <= imask_d;
         fifoc_q <= fifoc_d;
         mcr_q <= mcr_d;
         spr_q <= spr_d;
         emsr_q <= emsr_d;
         chars_q <= chars_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign divisor_o = {dvhi_q, dvlo_q};
   assign fraction_o = frac_q;
   assign feature_o = feat_q;
   assign enhanced_o = enh_q;
   assign line_ctrl_o = lctl_q;
   assign modem_ctrl_o = mcr_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_mask_upper_lock:
      assert property ((wr_i && norm_sel && addr_i == OFS_MASK && !ext_on)
         |=> imask_q[7:4] == $past(imask_q[7:4]))
      else $error("upper mask bits changed while locked");
   a_mask_upper_open:
      assert property ((wr_i && norm_sel && addr_i == OFS_MASK && ext_on)
         |=> imask_q == $past(wdata_i))
      else $error("unlocked mask write not stored");
   a_frac_gate:
      assert property ((wr_i && div_bank && addr_i == OFS_FRACTION
         && !ext_on) |=> $stable(frac_q))
      else $error("fraction written while locked");
   a_rx_irq_raise:
      assert property ((fifoc_q[0] && imask_q[0] && !ev.empty
         && ev.level >= ev.trigger) |=> irq_o)
      else $error("rx interrupt missing at trigger");
   a_rx_irq_drop:
      assert property ((fifoc_q[0] && ev.level < ev.trigger
         && imask_q[3:1] == 3'h0) |=> !irq_o)
      else $error("rx interrupt held below trigger");
   a_src_rx_code:
      assert property ((rd_i && norm_sel && addr_i == OFS_SRC && fifoc_q[0]
         && imask_q[0] && !ev.empty && ev.level >= ev.trigger
         && !(imask_q[2] && line_err_i)) |=> rdata_o[3:0] == SRC_RX)
      else $error("source does not show rx level");
   a_ready_flag:
      assert property ((rd_i && norm_sel && addr_i == OFS_LINE_STAT)
         |=> rdata_o[0] == !$past(ev.empty))
      else $error("data ready flag wrong");
   a_enh_chars:
      assert property ((rd_i && !wr_i && enh_bank && addr_i == OFS_RESUME1)
         |=> rdata_o == chars_q[0])
      else $error("flow character read wrong");
   a_level_read:
      assert property ((rd_i && enh_bank && addr_i == OFS_TRIGGER)
         |=> rdata_o == $past(ev.level))
      else $error("level counter read wrong");
   a_id_read:
      assert property ((rd_i && div_bank && addr_i == OFS_DIV_HIGH
         && divs_zero) |=> rdata_o == DEVICE_ID)
      else $error("identity read wrong");
endmodule : uart_regmap_top

//--- testbench/host_model.sv
/*
 Host processor model driving the UART channel register bus.
 Assumes the synchronous strobe bus of the register map top module.
*/
`timescale 1ns/1ps
module host_model
   import uart_regmap_pkg::*;
(
   input wire logic clk_i,
   output logic [2:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   initial begin
      addr_o = 3'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end

   // Released lines flip, so a stale address never looks valid
   task automatic cycle(input logic [2:0] a, input logic w,
      input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = w;
      rd_o = !w;
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : cycle

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      cycle(a, 1'b1, d);
   endtask : wr_reg

   // Read data holds until the next read, so the next edge is safe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      cycle(a, 1'b0, ~wdata_o);
      @(posedge clk_i);
      d = rdata_i;
      #1;
   endtask : rd_reg

   // Bank choice only through line control
   task automatic set_line(input logic [7:0] v);
      wr_reg(OFS_LINE_CTRL, v);
   endtask : set_line
endmodule : host_model

//--- testbench/testbench.sv
/*
 Self-checking testbench for the UART channel register map.
 Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module testbench;
   import uart_regmap_pkg::*;
   // Arbitrary identification values
   localparam logic [7:0] DEV_ID = 8'h3a;
   localparam logic [7:0] REV = 8'h02;
   logic clk_i, sys_rst_i, wr_i, rd_i, rx_push_i, irq_o;
   logic tx_empty_i, line_err_i, modem_chg_i;
   logic [2:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rx_char_i, modem_stat_i, feature_o;
   logic [7:0] enhanced_o, line_ctrl_o, modem_ctrl_o, v;
   logic [15:0] divisor_o;
   logic [3:0] fraction_o;
   int fail_count = 0;
   int checks = 0;

   // ---------------------------------------------------------------
   // Instances and clock
   // ---------------------------------------------------------------
   uart_regmap_top #(.DEVICE_ID(DEV_ID), .REVISION(REV)) i_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .rx_push_i(rx_push_i), .rx_char_i(rx_char_i),
      .tx_empty_i(tx_empty_i), .line_err_i(line_err_i),
      .modem_chg_i(modem_chg_i), .modem_stat_i(modem_stat_i),
      .irq_o(irq_o), .divisor_o(divisor_o), .fraction_o(fraction_o),
      .feature_o(feature_o), .enhanced_o(enhanced_o),
      .line_ctrl_o(line_ctrl_o), .modem_ctrl_o(modem_ctrl_o));
   host_model i_host (.clk_i(clk_i), .addr_o(addr_i), .wr_o(wr_i),
      .rd_o(rd_i), .wdata_o(wdata_i), .rdata_i(rdata_o));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input string n, input logic [15:0] seen,
      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", n, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input string n, input logic [2:0] a,
      input logic [7:0] e);
      i_host.rd_reg(a, v);
      check(n, 16'(v), 16'(e));
   endtask : rd_chk

   task automatic settle;
      @(posedge clk_i);
      #1;
   endtask : settle

   task automatic push(input logic [7:0] c);
      settle();
      rx_push_i = 1'b1;
      rx_char_i = c;
      settle();
      rx_push_i = 1'b0;
      rx_char_i = ~c;
   endtask : push

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_ident;
      check("line_ctrl_o", 16'(line_ctrl_o), 16'h0000);
      check("divisor_o", divisor_o, 16'h0000);
      i_host.set_line(8'h80);
      rd_chk("device_id", 3'h1, DEV_ID);
      rd_chk("revision", 3'h0, REV);
      i_host.wr_reg(OFS_DIV_LOW, 8'h05);
      rd_chk("divisor_low", 3'h0, 8'h05);
      check("divisor_o", divisor_o, 16'h0005);
      i_host.wr_reg(OFS_DIV_LOW, 8'h00);
   endtask : t_ident

   task automatic t_enh;
      i_host.set_line(ENH_BANK_KEY);
      for (int i = 4; i < 8; i++) begin
         i_host.wr_reg(3'(i), 8'h10 + 8'(i));
      end
      for (int i = 4; i < 8; i++) begin
         rd_chk("flow_char", 3'(i), 8'h10 + 8'(i));
      end
      // Bit 2 stays 0 on channel A
      i_host.wr_reg(OFS_FEATURE, 8'hff);
      rd_chk("feature", OFS_FEATURE, 8'hfb);
      check("feature_o", 16'(feature_o), 16'h00fb);
      i_host.wr_reg(OFS_FEATURE, 8'h00);
   endtask : t_enh

   task automatic t_gate;
      i_host.wr_reg(OFS_ENHANCED, 8'h00);
      i_host.set_line(8'h00);
      i_host.wr_reg(OFS_MASK, 8'hff);
      i_host.wr_reg(OFS_MODEM_CTRL, 8'hff);
      rd_chk("mask_locked", OFS_MASK, 8'h0f);
      check("modem_locked", 16'(modem_ctrl_o), 16'h001f);
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_ENHANCED, 8'h10);
      check("enhanced_o", 16'(enhanced_o), 16'h0010);
      i_host.set_line(8'h00);
      i_host.wr_reg(OFS_MASK, 8'hff);
      i_host.wr_reg(OFS_MODEM_CTRL, 8'hff);
      rd_chk("mask_open", OFS_MASK, 8'hff);
      check("modem_open", 16'(modem_ctrl_o), 16'h00ff);
      i_host.wr_reg(OFS_MASK, 8'h00);
   endtask : t_gate

   task automatic t_frac;
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_ENHANCED, 8'h00);
      i_host.set_line(8'h80);
      i_host.wr_reg(OFS_FRACTION, 8'hab);
      check("fraction_locked", 16'(fraction_o), 16'h0000);
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_ENHANCED, 8'h10);
      i_host.set_line(8'h80);
      i_host.wr_reg(OFS_FRACTION, 8'hab);
      check("fraction_o", 16'(fraction_o), 16'h000b);
      rd_chk("fraction", OFS_FRACTION, 8'h0b);
      i_host.set_line(8'h00);
   endtask : t_frac

   // Trigger 4 from fifo control bits 7:6 = 01
   task automatic t_rx;
      i_host.wr_reg(OFS_SRC, 8'h43);
      i_host.wr_reg(OFS_MASK, 8'h01);
      rd_chk("ready_empty", OFS_LINE_STAT, 8'h00);
      for (int i = 0; i < 3; i++) begin
         push(8'h31 + 8'(i));
      end
      settle();
      check("irq_below", 16'(irq_o), 16'h0000);
      rd_chk("ready_set", OFS_LINE_STAT, 8'h01);
      push(8'h34);
      settle();
      check("irq_reach", 16'(irq_o), 16'h0001);
      rd_chk("src_rx", OFS_SRC, 8'hc4);
      rd_chk("rx_data", OFS_DATA, 8'h31);
      settle();
      check("irq_drop", 16'(irq_o), 16'h0000);
      rd_chk("src_clear", OFS_SRC, 8'hc1);
      for (int i = 1; i < 4; i++) begin
         rd_chk("rx_data", OFS_DATA, 8'h31 + 8'(i));
      end
      rd_chk("ready_clear", OFS_LINE_STAT, 8'h00);
   endtask : t_rx

   task automatic t_mask;
      logic [7:0] m[5] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h01};
      logic [7:0] s[5] = '{8'h01, 8'h02, 8'h06, 8'h00, 8'h01};
      i_host.wr_reg(OFS_SRC, 8'h00);
      tx_empty_i = 1'b1;
      line_err_i = 1'b1;
      modem_chg_i = 1'b1;
      for (int i = 0; i < 5; i++) begin
         i_host.wr_reg(OFS_MASK, m[i]);
         rd_chk("src_masked", OFS_SRC, s[i]);
         check("irq_masked", 16'(irq_o), 16'(s[i] != 8'h01));
      end
      // Non-FIFO mode: one held character is enough
      push(8'h55);
      rd_chk("src_rx_plain", OFS_SRC, 8'h04);
      rd_chk("rx_plain", OFS_DATA, 8'h55);
      rd_chk("modem_stat", OFS_MODEM_STAT, 8'h5a);
      modem_stat_i = 8'ha5;
      rd_chk("modem_stat", OFS_MODEM_STAT, 8'ha5);
      tx_empty_i = 1'b0;
      line_err_i = 1'b0;
      modem_chg_i = 1'b0;
   endtask : t_mask

   // Trigger register selected by feature bits 5:4 = 11
   task automatic t_trig;
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_FEATURE, 8'h30);
      i_host.wr_reg(OFS_TRIGGER, 8'h02);
      i_host.set_line(8'h00);
      i_host.wr_reg(OFS_SRC, 8'h01);
      i_host.wr_reg(OFS_MASK, 8'h01);
      push(8'h41);
      settle();
      check("irq_trg_below", 16'(irq_o), 16'h0000);
      push(8'h42);
      settle();
      check("irq_trg_reach", 16'(irq_o), 16'h0001);
      i_host.set_line(ENH_BANK_KEY);
      rd_chk("fifo_level", OFS_TRIGGER, 8'h02);
      settle();
      check("irq_level_read", 16'(irq_o), 16'h0001);
   endtask : t_trig

   // Swapped scratch slot shows the fill level, here 2
   task automatic t_scratch;
      i_host.set_line(8'h00);
      i_host.wr_reg(OFS_SCRATCH, 8'ha5);
      rd_chk("scratch", OFS_SCRATCH, 8'ha5);
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_FEATURE, 8'h40);
      i_host.set_line(8'h00);
      i_host.wr_reg(OFS_SCRATCH, 8'h5a);
      rd_chk("scratch_swap", OFS_SCRATCH, 8'h02);
      i_host.set_line(ENH_BANK_KEY);
      i_host.wr_reg(OFS_FEATURE, 8'h00);
      i_host.set_line(8'h00);
      rd_chk("scratch_kept", OFS_SCRATCH, 8'ha5);
   endtask : t_scratch

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic end_sim;
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      sys_rst_i = 1'b1;
      rx_push_i = 1'b0;
      rx_char_i = 8'h00;
      tx_empty_i = 1'b0;
      line_err_i = 1'b0;
      modem_chg_i = 1'b0;
      modem_stat_i = 8'h5a;
      repeat (2) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      t_ident();
      t_enh();
      t_gate();
      t_frac();
      t_rx();
      t_mask();
      t_trig();
      t_scratch();
      end_sim();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end
endmodule : testbench
